// *** shared/gauge_defines.svh ***
// Command codes, bit positions, reset values and timing figures of the gauge command bank
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH
`define SLAVE_ADDR 7'h0b
`define BITS_PER_BYTE 4'h8
`define CMD_TEMP 8'h08
`define CMD_VOLT 8'h09
`define CMD_CURR 8'h0a
`define CMD_AVG_CURR 8'h0b
`define CMD_ERR 8'h0c
`define CMD_REL_SOC 8'h0d
`define CMD_ABS_SOC 8'h0e
`define CMD_CAP_LEFT 8'h0f
`define CMD_FULL_CAP 8'h10
`define CMD_MIN_NOW 8'h11
`define CMD_MIN_AVG 8'h12
`define CMD_MIN_FULL 8'h13
`define CMD_CHG_CUR 8'h14
`define CMD_CHG_VOLT 8'h15
`define CMD_STATUS 8'h16
`define CMD_CYCLES 8'h17
`define CMD_DESIGN 8'h18
`define CMD_FLAGS 8'h2f
`define RST_TEMP 16'h0b72
`define RST_ERR 16'h0064
`define PCT_MAX 16'h0064
`define WORD_INVALID 16'hffff
`define WORD_MAX_MIN 16'hfffe
`define CYCLE_DROP 9'h00f
`define ST_OVERCHG 15
`define ST_TERMCHG 14
`define ST_OVERTEMP 12
`define ST_TERMDIS 11
`define ST_LOWCAP 9
`define ST_LOWTIME 8
`define ST_INIT 7
`define ST_DISCH 6
`define ST_FULL 5
`define ST_EMPTY 4
`define ST_ERR_MSB 3
`define CFG_FLAG_MASK 8'hf7
`define COND_FLAG_MASK 8'hef
`define TMR_W 33
`define MCLK_KHZ 64'h0000_0000_0001_86a0
`define SAVE_DEADLINE_MS 64'h0000_0000_0000_0190
`define AVG_SETTLE_MS 64'h0000_0000_0000_ea60
`endif

// *** shared/gauge_pkg.sv ***
// Types shared by the gauge command bank and its link sampler
`include "gauge_defines.svh"
`default_nettype none
package gauge_pkg;
   typedef logic [15:0] word_t;
   typedef logic [`TMR_W-1:0] tick_t;
   typedef enum logic [3:0] {
      LK_IDLE = 4'h0, LK_ADDR = 4'h1, LK_ADDR_ACK = 4'h2, LK_CMD = 4'h3, LK_CMD_ACK = 4'h4,
      LK_WDATA = 4'h5, LK_WDATA_ACK = 4'h6, LK_TX = 4'h7, LK_TX_ACK = 4'h8
   } link_state_e;
   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic start;
      logic stop;
   } sampler_s;
   typedef struct packed {
      link_state_e st;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic [7:0] cmd;
      logic rd;
      logic hi_byte;
      logic ack_seen;
      word_t tx_word;
      logic sda_o;
      logic sda_oe;
      word_t temp, volt, curr, avg_curr, err, full_cap, cycles;
      logic initialized, avg_ok;
      tick_t settle_tmr;
      logic [7:0] soc_base;
      logic cycle_armed, fcc_dirty, cyc_dirty;
      logic ee_valid, ee_sel;
      word_t ee_data;
      tick_t save_tmr;
      logic save_late;
      word_t sent_cur, sent_volt;
      logic bc_valid;
      logic [7:0] bc_cmd;
      word_t bc_word;
   } gauge_s;
endpackage
`default_nettype wire

// *** shared/link_evt_if.sv ***
// Filtered bus events passed from the link sampler to the command bank
`default_nettype none
interface link_evt_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   modport src (output scl_rise, scl_fall, start, stop, sda);
   modport snk (input scl_rise, scl_fall, start, stop, sda);
endinterface
`default_nettype wire

// *** hdl/link_sampler.sv ***
// Synchronises the two-wire bus pins and reports edges, start and stop
`default_nettype none
module link_sampler
   import gauge_pkg::*;
(
   input wire logic mclk,    // System clock
   input wire logic srst,    // Synchronous reset
   input wire logic ce,      // Clock enable
   input wire logic smbc_in, // Bus clock pin level
   input wire logic smbd_in, // Bus data pin level
   link_evt_if.src ev        // Filtered events
);
   sampler_s r, n;

   always_comb begin
      n = r;
      n.scl_sync = {r.scl_sync[1:0], smbc_in};
      n.sda_sync = {r.sda_sync[1:0], smbd_in};
      // A level counts only once the last two stages agree
      if (r.scl_sync[1] == r.scl_sync[2]) begin
         n.scl = r.scl_sync[2];
      end
      if (r.sda_sync[1] == r.sda_sync[2]) begin
         n.sda = r.sda_sync[2];
      end
      n.rise = ~r.scl & n.scl;
      n.fall = r.scl & ~n.scl;
      // Data moving while the clock is steady high frames a transfer
      n.start = r.scl & n.scl & r.sda & ~n.sda;
      n.stop = r.scl & n.scl & ~r.sda & n.sda;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= '0;
         r.scl_sync <= 3'h7;
         r.sda_sync <= 3'h7;
         r.scl <= 1'b1;
         r.sda <= 1'b1;
      end else if (ce) begin
         r <= n;
      end
   end

   assign ev.scl_rise = r.rise;
   assign ev.scl_fall = r.fall;
   assign ev.start = r.start;
   assign ev.stop = r.stop;
   assign ev.sda = r.sda;
endmodule
`default_nettype wire

// *** hdl/gauge_cmd_regs.sv ***
// Read-only battery data command bank behind the two-wire slave port
//
// Functional notes
// - Commands answer read-word: code, then 16-bit word
// - 0x08 returns temperature in tenth kelvin
// - 0x09 returns pack voltage in millivolts
// - 0x0a returns signed current, positive charging
// - 0x0b returns averaged current, valid after minute
// - 0x0c returns error margin, limited to 100
// - 0x0d returns percent of learned full capacity
// - 0x0e returns percent of design, may exceed
// - 0x0f returns remaining capacity in mAh
// - 0x10 returns full capacity, stored until learned
// - Learned full capacity saved to EEPROM promptly
// - 0x11 minutes from current, 65535 unless discharging
// - 0x12 minutes from average, 65535 unless discharging
// - 0x13 minutes to full, 65535 unless charging
// - 0x14 charge current request, broadcast when enabled
// - 0x15 charge voltage request, broadcast when enabled
// - Status alarm bits at fixed masks, two reserved
// - Status state bits plus low error nibble
// - Low capacity alarm from current, low time alarm from average
// - Cycle counts after 15 percent drop, saved
// - Cycle count saturates at 65535
// - Two flag bytes with fixed bit layout
// - 0x18 returns design capacity in mAh
`include "gauge_defines.svh"
`default_nettype none
module gauge_cmd_regs #(
   parameter longint unsigned SAVE_CYCLES = `SAVE_DEADLINE_MS * `MCLK_KHZ,
   parameter longint unsigned SETTLE_CYCLES = `AVG_SETTLE_MS * `MCLK_KHZ
) (
   input wire logic mclk,                     // System clock, 100 MHz
   input wire logic srst,                     // Synchronous reset
   input wire logic ce,                       // Clock enable
   input wire logic smbc_in,                  // Bus clock pin
   input wire logic smbd_in,                  // Bus data pin level
   output logic smbd_out,                     // Bus data drive value
   output logic smbd_oe,                      // Bus data pull-down enable
   input wire logic meas_valid,               // New measurement set
   input wire gauge_pkg::word_t meas_temp,    // Temperature sample
   input wire gauge_pkg::word_t meas_volt,    // Voltage sample
   input wire gauge_pkg::word_t meas_curr,    // Signed current sample
   input wire gauge_pkg::word_t meas_avg,     // Signed averaged current
   input wire gauge_pkg::word_t meas_err,     // Error margin estimate
   input wire gauge_pkg::word_t soc_rel,      // Percent of full estimate
   input wire gauge_pkg::word_t soc_abs,      // Percent of design estimate
   input wire gauge_pkg::word_t cap_left,     // Remaining capacity
   input wire gauge_pkg::word_t min_now_raw,  // Minutes left at current
   input wire gauge_pkg::word_t min_avg_raw,  // Minutes left at average
   input wire gauge_pkg::word_t min_full_raw, // Minutes to full
   input wire logic ee_loaded,                // EEPROM image loaded
   input wire gauge_pkg::word_t ee_full_cap,  // Stored full capacity
   input wire gauge_pkg::word_t ee_cycles,    // Stored cycle count
   input wire gauge_pkg::word_t design_cap,   // Design capacity
   input wire logic learn_valid,              // New capacity learned
   input wire gauge_pkg::word_t learn_cap,    // Learned capacity
   input wire logic charge_done,              // End of charge seen
   input wire gauge_pkg::word_t chg_cur_req,  // Wanted charge current
   input wire gauge_pkg::word_t chg_volt_req, // Wanted charge voltage
   input wire logic bcast_enable,             // Broadcasts allowed
   input wire logic bcast_done,               // Broadcast engine took word
   input wire logic [3:0] alarm_in,           // Overchg, termchg, overtemp, termdis
   input wire logic pack_full,                // Fully charged state
   input wire logic pack_empty,               // Fully discharged state
   input wire logic [3:0] err_code,           // Status error code
   input wire gauge_pkg::word_t cap_alarm,    // Low capacity threshold
   input wire gauge_pkg::word_t time_alarm,   // Low time threshold
   input wire logic [7:0] cfg_flags,          // Configuration flag byte
   input wire logic [7:0] cond_flags,         // Condition flag byte
   output logic ee_wr_valid,                  // EEPROM save request
   output logic ee_wr_sel,                    // 0 full capacity, 1 cycles
   output gauge_pkg::word_t ee_wr_data,       // Word to save
   input wire logic ee_wr_done,               // Save accepted
   output logic ee_save_late,                 // Save missed its deadline
   output logic bcast_valid,                  // Charger broadcast pending
   output logic [7:0] bcast_cmd,              // Broadcast command code
   output gauge_pkg::word_t bcast_word        // Broadcast value
);
   import gauge_pkg::*;

   gauge_s r, n;
   link_evt_if ev ();

   link_sampler u_sampler (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .smbc_in(smbc_in),
      .smbd_in(smbd_in),
      .ev(ev)
   );

   function automatic word_t pct_limit(input word_t v);
      return (v > `PCT_MAX) ? `PCT_MAX : v;
   endfunction

   // Invalid marker when inactive; keep real estimates off the marker
   function automatic word_t sat_minutes(input word_t raw, input logic active);
      if (!active) begin
         return `WORD_INVALID;
      end
      return (raw == `WORD_INVALID) ? `WORD_MAX_MIN : raw;
   endfunction

   function automatic logic cmd_known(input logic [7:0] c);
      return (c inside {[`CMD_TEMP:`CMD_DESIGN]}) || (c == `CMD_FLAGS);
   endfunction

   function automatic word_t status_word();
      word_t w;
      w = '0;
      w[`ST_OVERCHG] = alarm_in[3];
      w[`ST_TERMCHG] = alarm_in[2];
      w[`ST_OVERTEMP] = alarm_in[1];
      w[`ST_TERMDIS] = alarm_in[0];
      w[`ST_LOWCAP] = r.curr[15] && (cap_left < cap_alarm);
      w[`ST_LOWTIME] = sat_minutes(min_avg_raw, r.avg_curr[15]) < time_alarm;
      w[`ST_INIT] = r.initialized;
      w[`ST_DISCH] = r.curr[15];
      w[`ST_FULL] = pack_full;
      w[`ST_EMPTY] = pack_empty;
      w[`ST_ERR_MSB:0] = err_code;
      return w;
   endfunction

   function automatic word_t read_word(input logic [7:0] c);
      word_t w;
      w = '0;
      case (c)
         `CMD_TEMP: w = r.temp;
         `CMD_VOLT: w = r.volt;
         `CMD_CURR: w = r.curr;
         `CMD_AVG_CURR: w = r.avg_ok ? r.avg_curr : '0;
         `CMD_ERR: w = pct_limit(r.err);
         `CMD_REL_SOC: w = pct_limit(soc_rel);
         `CMD_ABS_SOC: w = soc_abs;
         `CMD_CAP_LEFT: w = cap_left;
         `CMD_FULL_CAP: w = r.full_cap;
         `CMD_MIN_NOW: w = sat_minutes(min_now_raw, r.curr[15]);
         `CMD_MIN_AVG: w = sat_minutes(min_avg_raw, r.avg_curr[15]);
         `CMD_MIN_FULL: w = sat_minutes(min_full_raw, !r.avg_curr[15] && (r.avg_curr != '0));
         `CMD_CHG_CUR: w = chg_cur_req;
         `CMD_CHG_VOLT: w = chg_volt_req;
         `CMD_STATUS: w = status_word();
         `CMD_CYCLES: w = r.cycles;
         `CMD_DESIGN: w = design_cap;
         `CMD_FLAGS: w = {cfg_flags & `CFG_FLAG_MASK, cond_flags & `COND_FLAG_MASK};
         default: w = '0;
      endcase
      return w;
   endfunction

   always_comb begin
      word_t rw;
      rw = read_word(r.cmd);
      n = r;

      if (meas_valid) begin
         n.temp = meas_temp;
         n.volt = meas_volt;
         n.curr = meas_curr;
         n.avg_curr = meas_avg;
         n.err = meas_err;
      end

      // Averaging window needs a full minute before it means anything
      if (!r.avg_ok) begin
         n.settle_tmr = r.settle_tmr + tick_t'(1);
         if (r.settle_tmr == tick_t'(SETTLE_CYCLES - 1)) begin
            n.avg_ok = 1'b1;
         end
      end

      if (ee_loaded) begin
         n.full_cap = ee_full_cap;
         n.cycles = ee_cycles;
         n.initialized = 1'b1;
      end

      // EEPROM writer serves one word at a time; clear before set so a new event wins
      if (r.ee_valid && ee_wr_done) begin
         n.ee_valid = 1'b0;
      end else if (!r.ee_valid && r.fcc_dirty) begin
         n.ee_valid = 1'b1;
         n.ee_sel = 1'b0;
         n.ee_data = r.full_cap;
         n.fcc_dirty = 1'b0;
      end else if (!r.ee_valid && r.cyc_dirty) begin
         n.ee_valid = 1'b1;
         n.ee_sel = 1'b1;
         n.ee_data = r.cycles;
         n.cyc_dirty = 1'b0;
      end

      if (learn_valid) begin
         n.full_cap = learn_cap;
         n.fcc_dirty = 1'b1;
      end

      if (charge_done) begin
         n.soc_base = 8'(pct_limit(soc_rel));
         n.cycle_armed = 1'b1;
      end else if (r.cycle_armed && r.curr[15] &&
                   ({1'b0, 8'(pct_limit(soc_rel))} + `CYCLE_DROP <= {1'b0, r.soc_base})) begin
         n.cycle_armed = 1'b0;
         n.cyc_dirty = 1'b1;
         if (r.cycles != `WORD_INVALID) begin
            n.cycles = r.cycles + 16'h0001;
         end
      end

      // Deadline watch covers queueing plus the EEPROM handshake
      if (r.ee_valid || r.fcc_dirty || r.cyc_dirty) begin
         if (r.save_tmr == tick_t'(SAVE_CYCLES - 1)) begin
            n.save_late = 1'b1;
         end else begin
            n.save_tmr = r.save_tmr + tick_t'(1);
         end
      end else begin
         n.save_tmr = '0;
      end

      if (r.bc_valid && bcast_done) begin
         n.bc_valid = 1'b0;
      end else if (!r.bc_valid && bcast_enable && (chg_cur_req != r.sent_cur)) begin
         n.bc_valid = 1'b1;
         n.bc_cmd = `CMD_CHG_CUR;
         n.bc_word = chg_cur_req;
         n.sent_cur = chg_cur_req;
      end else if (!r.bc_valid && bcast_enable && (chg_volt_req != r.sent_volt)) begin
         n.bc_valid = 1'b1;
         n.bc_cmd = `CMD_CHG_VOLT;
         n.bc_word = chg_volt_req;
         n.sent_volt = chg_volt_req;
      end

      if (ev.stop) begin
         n.st = LK_IDLE;
         n.sda_oe = 1'b0;
      end else if (ev.start) begin
         n.st = LK_ADDR;
         n.bit_cnt = '0;
         n.sda_oe = 1'b0;
      end else begin
         unique case (r.st)
            LK_IDLE: begin
            end
            LK_ADDR, LK_CMD, LK_WDATA: begin
               if (ev.scl_rise) begin
                  n.shreg = {r.shreg[6:0], ev.sda};
                  n.bit_cnt = r.bit_cnt + 4'h1;
               end else if (ev.scl_fall && r.bit_cnt == `BITS_PER_BYTE) begin
                  n.bit_cnt = '0;
                  if (r.st == LK_ADDR) begin
                     if (r.shreg[7:1] == `SLAVE_ADDR) begin
                        n.rd = r.shreg[0];
                        n.st = LK_ADDR_ACK;
                        n.sda_oe = 1'b1;
                     end else begin
                        n.st = LK_IDLE;
                     end
                  end else if (r.st == LK_CMD) begin
                     if (cmd_known(r.shreg)) begin
                        n.cmd = r.shreg;
                        n.st = LK_CMD_ACK;
                        n.sda_oe = 1'b1;
                     end else begin
                        n.st = LK_IDLE;
                     end
                  end else begin
                     n.st = LK_WDATA_ACK;
                     n.sda_oe = 1'b1;
                  end
               end
            end
            LK_ADDR_ACK, LK_CMD_ACK, LK_WDATA_ACK: begin
               if (ev.scl_fall) begin
                  n.sda_oe = 1'b0;
                  if (r.st == LK_ADDR_ACK && r.rd) begin
                     // Whole word is frozen here so both bytes come from one sample
                     n.tx_word = rw;
                     n.shreg = rw[7:0];
                     n.hi_byte = 1'b0;
                     n.sda_oe = ~rw[7];
                     n.st = LK_TX;
                  end else if (r.st == LK_ADDR_ACK) begin
                     n.st = LK_CMD;
                  end else begin
                     n.st = LK_WDATA;
                  end
               end
            end
            LK_TX: begin
               if (ev.scl_rise) begin
                  n.bit_cnt = r.bit_cnt + 4'h1;
               end else if (ev.scl_fall) begin
                  if (r.bit_cnt == `BITS_PER_BYTE) begin
                     n.bit_cnt = '0;
                     n.sda_oe = 1'b0;
                     n.st = LK_TX_ACK;
                  end else begin
                     n.shreg = {r.shreg[6:0], 1'b0};
                     n.sda_oe = ~r.shreg[6];
                  end
               end
            end
            LK_TX_ACK: begin
               if (ev.scl_rise) begin
                  n.ack_seen = ~ev.sda;
               end else if (ev.scl_fall) begin
                  if (r.ack_seen && !r.hi_byte) begin
                     n.shreg = r.tx_word[15:8];
                     n.hi_byte = 1'b1;
                     n.sda_oe = ~r.tx_word[15];
                     n.st = LK_TX;
                  end else begin
                     n.st = LK_IDLE;
                  end
               end
            end
            default: begin
               n.st = LK_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= '0;
         r.temp <= `RST_TEMP;
         r.err <= `RST_ERR;
      end else if (ce) begin
         r <= n;
      end
   end

   assign smbd_out = r.sda_o;
   assign smbd_oe = r.sda_oe;
   assign ee_wr_valid = r.ee_valid;
   assign ee_wr_sel = r.ee_sel;
   assign ee_wr_data = r.ee_data;
   assign ee_save_late = r.save_late;
   assign bcast_valid = r.bc_valid;
   assign bcast_cmd = r.bc_cmd;
   assign bcast_word = r.bc_word;
endmodule
`default_nettype wire

// *** bench/gauge_cmd_regs_assertions.sv ***
// Port assertions for the gauge command bank
`default_nettype none
module gauge_cmd_regs_assertions #(
   parameter longint unsigned SAVE_CYCLES = 50
) (
   input wire logic mclk, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic smbd_out, // Data drive value
   input wire logic smbd_oe, // Data pull enable
   input wire logic learn_valid, // New capacity
   input wire logic ee_wr_valid, // Save request
   input wire logic ee_wr_sel, // Save select
   input wire gauge_pkg::word_t ee_wr_data, // Save word
   input wire logic ee_wr_done, // Save taken
   input wire logic ee_save_late, // Save overdue
   input wire logic bcast_enable, // Broadcasts allowed
   input wire logic bcast_valid, // Broadcast pending
   input wire logic [7:0] bcast_cmd, // Broadcast code
   input wire gauge_pkg::word_t bcast_word, // Broadcast word
   input wire logic bcast_done // Broadcast taken
);
   timeunit 1ns;
   timeprecision 1ps;
   import gauge_pkg::*;
   longint unsigned pend;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   always_ff @(posedge mclk) begin
      pend <= (srst || !ee_wr_valid) ? 64'h0000_0000_0000_0000 : pend + 64'h0000_0000_0000_0001;
   end
   sequence s_save_wait;
      ee_wr_valid && !ee_wr_done;
   endsequence
   sequence s_save_kept;
      ee_wr_valid && $stable(ee_wr_sel) && $stable(ee_wr_data);
   endsequence
   sequence s_bc_wait;
      bcast_valid && !bcast_done;
   endsequence
   sequence s_bc_kept;
      bcast_valid && $stable(bcast_cmd) && $stable(bcast_word);
   endsequence
   a_line_low: assert property (!smbd_out)
      else $error("data line driven high");
   a_reset_quiet: assert property ($fell(srst) |-> !smbd_oe && !ee_wr_valid && !bcast_valid)
      else $error("outputs active after reset");
   a_save_holds: assert property (s_save_wait |=> s_save_kept)
      else $error("save request dropped or changed");
   a_learn_saves: assert property (learn_valid && !ee_wr_valid |-> ##[1:2] (ee_wr_valid && !ee_wr_sel))
      else $error("learned capacity not saved");
   a_late_cause: assert property ($rose(ee_save_late) |-> pend + 2 >= SAVE_CYCLES)
      else $error("save flagged late too early");
   a_bc_holds: assert property (s_bc_wait |=> s_bc_kept)
      else $error("broadcast dropped or changed");
   a_bc_code: assert property (bcast_valid |-> bcast_cmd inside {8'h14, 8'h15})
      else $error("broadcast code wrong");
   a_bc_gated: assert property ($rose(bcast_valid) |-> $past(bcast_enable))
      else $error("broadcast while disabled");
endmodule
bind gauge_cmd_regs gauge_cmd_regs_assertions #(.SAVE_CYCLES(SAVE_CYCLES)) i_chk (.mclk, .srst, .smbd_out,
   .smbd_oe, .learn_valid, .ee_wr_valid, .ee_wr_sel, .ee_wr_data, .ee_wr_done, .ee_save_late, .bcast_enable,
   .bcast_valid, .bcast_cmd, .bcast_word, .bcast_done);
`default_nettype wire

// *** bench/smbus_host_model.sv ***
// Two-wire bus host, one bit per 16 system clocks
`default_nettype none
module smbus_host_model (
   input wire logic mclk, // System clock
   input wire logic sda, // Resolved data line
   output logic scl, // Bus clock, idle high
   output logic sda_oe // High pulls data low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic q;
      repeat (4) @(posedge mclk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_oe <= !b;
      q;
      scl <= 1'b1;
      q;
      r = sda;
      q;
      scl <= 1'b0;
      q;
   endtask
   task automatic start;
      sda_oe <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      sda_oe <= 1'b1;
      q;
      scl <= 1'b0;
      q;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ackb, output logic [7:0] rx, output logic n);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ackb, n);
   endtask
   task automatic access(input logic [6:0] a, input logic [7:0] c, input logic wr, input logic [15:0] v,
                         output logic [15:0] w, output logic nak);
      logic [7:0] d;
      logic [3:0] n;
      n = 4'h0;
      w = 16'h0000;
      start;
      xfer({a, 1'b0}, 1'b1, d, n[0]);
      xfer(c, 1'b1, d, n[1]);
      if (wr) begin
         xfer(v[7:0], 1'b1, d, n[2]);
         xfer(v[15:8], 1'b1, d, n[3]);
      end else begin
         start;
         xfer({a, 1'b1}, 1'b1, d, n[2]);
         xfer(8'hff, 1'b0, w[7:0], d[0]);
         xfer(8'hff, 1'b1, w[15:8], d[0]);
      end
      sda_oe <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_oe <= 1'b0;
      q;
      nak = |n;
   endtask
endmodule
`default_nettype wire

// *** bench/gauge_cmd_regs_test.sv ***
// Self-checking bench for the gauge command bank
`include "gauge_defines.svh"
`default_nettype none
module gauge_cmd_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import gauge_pkg::*;
   logic mclk, srst, ce, smbc_in, smbd_in, smbd_out, smbd_oe, host_oe, nak, sv_sel;
   logic meas_valid, ee_loaded, learn_valid, charge_done, bcast_enable, bcast_done, ee_wr_done, ee_stall;
   logic pack_full, pack_empty, ee_wr_valid, ee_wr_sel, ee_save_late, bcast_valid;
   logic [3:0] alarm_in, err_code;
   logic [7:0] cfg_flags, cond_flags, bcast_cmd, bc_cmd;
   word_t meas_temp, meas_volt, meas_curr, meas_avg, meas_err, soc_rel, soc_abs, cap_left, min_now_raw;
   word_t min_avg_raw, min_full_raw, ee_full_cap, ee_cycles, design_cap, learn_cap, chg_cur_req;
   word_t chg_volt_req, cap_alarm, time_alarm, ee_wr_data, bcast_word, sv_data, bc_word, got;
   int mismatches, cmp_count, cycles;
   logic [7:0] cmds [16] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
      8'h13, 8'h16, 8'h17, 8'h18, 8'h2f};
   word_t exps [16] = '{16'h0c1c, 16'hffff, 16'h8000, 16'hfc18, 16'h0064, 16'h0064, 16'h012c, 16'h0100,
      16'h1000, 16'hfffe, 16'h0020, 16'hffff, 16'hdbd5, 16'hfffe, 16'h0800, 16'hf7ef};
   assign smbd_in = !(host_oe || smbd_oe);
   gauge_cmd_regs #(.SAVE_CYCLES(50), .SETTLE_CYCLES(100)) i_dut (.mclk, .srst, .ce, .smbc_in, .smbd_in,
      .smbd_out, .smbd_oe, .meas_valid, .meas_temp, .meas_volt, .meas_curr, .meas_avg, .meas_err, .soc_rel,
      .soc_abs, .cap_left, .min_now_raw, .min_avg_raw, .min_full_raw, .ee_loaded, .ee_full_cap, .ee_cycles,
      .design_cap, .learn_valid, .learn_cap, .charge_done, .chg_cur_req, .chg_volt_req, .bcast_enable,
      .bcast_done, .alarm_in, .pack_full, .pack_empty, .err_code, .cap_alarm, .time_alarm, .cfg_flags,
      .cond_flags, .ee_wr_valid, .ee_wr_sel, .ee_wr_data, .ee_wr_done, .ee_save_late, .bcast_valid,
      .bcast_cmd, .bcast_word);
   smbus_host_model i_host (.mclk, .sda(smbd_in), .scl(smbc_in), .sda_oe(host_oe));
   task automatic chk(input string what, input word_t exp, input word_t seen);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] c, input word_t exp);
      i_host.access(`SLAVE_ADDR, c, 1'b0, 16'h0000, got, nak);
      chk($sformatf("code %h", c), exp, got);
      chk("ack", 16'h0000, {15'h0000, nak});
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = !mclk;
   end
   // Far side takes each save and broadcast a cycle later; a stalled save waits until it is late
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      ee_wr_done <= ee_wr_valid && !ee_wr_done && (!ee_stall || ee_save_late);
      bcast_done <= bcast_valid && !bcast_done;
      if (ee_wr_valid && !ee_wr_done) {sv_sel, sv_data} <= {ee_wr_sel, ee_wr_data};
      if (bcast_valid && !bcast_done) {bc_cmd, bc_word} <= {bcast_cmd, bcast_word};
      if (cycles == 60000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      {meas_valid, ee_loaded, learn_valid, charge_done, bcast_enable, pack_full, pack_empty, alarm_in} = '0;
      {meas_temp, meas_volt, meas_curr, meas_avg, meas_err, soc_rel, soc_abs, cap_left, min_now_raw} = '0;
      {min_avg_raw, min_full_raw, ee_full_cap, ee_cycles, design_cap, learn_cap, chg_cur_req} = '0;
      {chg_volt_req, cap_alarm, time_alarm, cfg_flags, cond_flags, err_code, ee_wr_done, bcast_done, ee_stall} = '0;
      {mismatches, cmp_count, cycles} = '0;
      {srst, ce} = 2'b11;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      rd(`CMD_TEMP, 16'h0b72);
      rd(`CMD_ERR, 16'h0064);
      {meas_temp, meas_volt, meas_curr, meas_avg, meas_err} <= {16'h0c1c, 16'hffff, 16'h8000, 16'hfc18, 16'h00c8};
      {soc_rel, soc_abs, cap_left, design_cap} <= {16'h0096, 16'h012c, 16'h0100, 16'h0800};
      {ee_full_cap, ee_cycles, min_now_raw, min_avg_raw} <= {16'h1000, 16'hfffe, 16'hffff, 16'h0020};
      {min_full_raw, cap_alarm, time_alarm} <= {16'h0030, 16'h0200, 16'h0030};
      {alarm_in, err_code, pack_empty, cfg_flags, cond_flags, meas_valid, ee_loaded} <= {9'h1eb, 16'hffff, 2'b11};
      @(posedge mclk);
      {meas_valid, ee_loaded} <= 2'b00;
      foreach (cmds[i]) rd(cmds[i], exps[i]);
      i_host.access(7'h0c, `CMD_TEMP, 1'b0, 16'h0000, got, nak);
      chk("foreign address", 16'h0001, {15'h0000, nak});
      i_host.access(`SLAVE_ADDR, 8'h20, 1'b0, 16'h0000, got, nak);
      chk("unknown code", 16'h0001, {15'h0000, nak});
      i_host.access(`SLAVE_ADDR, `CMD_TEMP, 1'b1, 16'h1234, got, nak);
      chk("write ack", 16'h0000, {15'h0000, nak});
      rd(`CMD_TEMP, 16'h0c1c);
      {meas_curr, meas_avg, meas_valid, pack_full} <= {16'h0100, 16'h0050, 2'b11};
      @(posedge mclk);
      meas_valid <= 1'b0;
      rd(`CMD_MIN_NOW, 16'hffff);
      rd(`CMD_MIN_AVG, 16'hffff);
      rd(`CMD_MIN_FULL, 16'h0030);
      rd(`CMD_STATUS, 16'hd8b5);
      {learn_cap, learn_valid, ee_stall} <= {16'h0f00, 2'b11};
      @(posedge mclk);
      learn_valid <= 1'b0;
      rd(`CMD_FULL_CAP, 16'h0f00);
      chk("saved word", 16'h0f00, sv_data);
      chk("saved select", 16'h0000, {15'h0000, sv_sel});
      chk("save late", 16'h0001, {15'h0000, ee_save_late});
      for (int k = 0; k < 2; k++) begin
         {meas_curr, soc_rel, meas_valid, charge_done} <= {16'h8000, 16'h005a, 2'b11};
         @(posedge mclk);
         {soc_rel, meas_valid, charge_done} <= {16'h004b, 2'b00};
         @(posedge mclk);
         rd(`CMD_CYCLES, 16'hffff);
      end
      chk("saved word", 16'hffff, sv_data);
      chk("saved select", 16'h0001, {15'h0000, sv_sel});
      {bcast_enable, chg_cur_req, chg_volt_req} <= {1'b1, 16'h0400, 16'hffff};
      rd(`CMD_CHG_CUR, 16'h0400);
      rd(`CMD_CHG_VOLT, 16'hffff);
      chk("broadcast code", 16'h0015, {8'h00, bc_cmd});
      chk("broadcast word", 16'hffff, bc_word);
      wrap_up;
   end
endmodule
`default_nettype wire
